//--- hdl/rsc_reset_source_controller.sv
`timescale 1ns/1ps
module rsc_reset_source_controller #(
    parameter int SOFT_DELAY_CYC = rsc_pkg::RSC_SOFT_DELAY_CYC,
    parameter int BROWN_FILT_CYC = rsc_pkg::RSC_BROWN_FILT_CYC,
    parameter int HOLD_CYC       = rsc_pkg::RSC_HOLD_CYC,
    parameter int CNT_W          = 16,
    parameter int FETCH_W        = 16,
    parameter int PORT_W         = 8
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               sys_rst,
    // ahb-lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    // supply monitor
    input  wire logic               supply_low_async,
    input  wire logic               power_down,
    output logic      [1:0]         brownout_threshold_sel,
    // watchdog
    input  wire logic               wdt_expire,
    input  wire logic               run_mode_normal,
    output logic                    wdt_enable,
    // reset outputs
    output logic                    core_reset,
    output logic                    por_active,
    output logic                    pc_sp_reset,
    output logic      [FETCH_W-1:0] fetch_addr,
    output logic      [PORT_W-1:0]  port_data_init,
    output logic      [PORT_W-1:0]  port_dir_init,
    // interrupt
    output logic                    irq
);
    import rsc_pkg::*;

    rsc_state_t                   state_reg;
    logic [CNT_W-1:0]             cnt_reg;
    logic [CNT_W-1:0]             filt_reg;
    logic                         sl_meta_reg;
    logic                         sl_sync_reg;
    logic [7:0]                   key_reg;
    logic [7:0]                   level_reg;
    logic [7:0]                   wdtctl_reg;
    logic [RSC_CAUSE_W-1:0]       cause_reg;
    logic [RSC_CAUSE_W-1:0]       cause_next;
    logic                         expire_reg;
    logic [RSC_IRQ_W-1:0]         irq_stat_reg;
    logic [RSC_IRQ_W-1:0]         irq_stat_next;
    logic [RSC_IRQ_W-1:0]         irq_mask_reg;
    logic [RSC_IRQ_W-1:0]         irq_evt;
    logic                         pend_key_reg;
    logic                         pend_lvl_reg;
    logic                         pend_wkey_reg;
    logic                         por_reg;
    logic                         pcsp_reg;
    logic [1:0]                   thr_reg;
    logic                         wr_pend_reg;
    logic [RSC_ADDR_W-1:0]        wr_addr_reg;
    logic [31:0]                  hrdata_reg;
    logic [31:0]                  rd_val;
    logic                         addr_ok;
    logic                         key_bad;
    logic                         lvl_bad;
    logic                         wkey_bad;
    logic                         brown_evt;
    logic                         wdt_run_evt;
    logic                         fire_hard;
    logic                         fire_soft;
    logic                         fire;
    logic                         wr_key;
    logic                         wr_cause;
    logic                         wr_level;
    logic                         wr_wdtctl;
    logic                         wr_status;
    logic                         wr_istat;
    logic                         wr_imask;

    // zero-wait slave: every transfer completes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;
    assign addr_ok   = hsel && hready && htrans[1];

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else begin
            wr_pend_reg <= addr_ok && hwrite && (haddr[31:RSC_ADDR_W] == '0);
            wr_addr_reg <= haddr[RSC_ADDR_W-1:0];
        end
    end

    assign wr_key    = wr_pend_reg && (wr_addr_reg == RSC_ADDR_KEY);
    assign wr_cause  = wr_pend_reg && (wr_addr_reg == RSC_ADDR_CAUSE);
    assign wr_level  = wr_pend_reg && (wr_addr_reg == RSC_ADDR_LEVEL);
    assign wr_wdtctl = wr_pend_reg && (wr_addr_reg == RSC_ADDR_WDTCTL);
    assign wr_status = wr_pend_reg && (wr_addr_reg == RSC_ADDR_STATUS);
    assign wr_istat  = wr_pend_reg && (wr_addr_reg == RSC_ADDR_IRQ_STAT);
    assign wr_imask  = wr_pend_reg && (wr_addr_reg == RSC_ADDR_IRQ_MASK);

    always_comb begin
        rd_val = 32'h0000_0000;
        if (haddr[31:RSC_ADDR_W] == '0) begin
            unique case (haddr[RSC_ADDR_W-1:0])
                RSC_ADDR_KEY:      rd_val[7:0] = key_reg;
                RSC_ADDR_CAUSE:    rd_val[RSC_CAUSE_W-1:0] = cause_reg;
                RSC_ADDR_LEVEL:    rd_val[7:0] = level_reg;
                RSC_ADDR_WDTCTL:   rd_val[7:0] = wdtctl_reg;
                RSC_ADDR_STATUS:   rd_val[RSC_STATUS_EXP] = expire_reg;
                RSC_ADDR_IRQ_STAT: rd_val[RSC_IRQ_W-1:0] = irq_stat_reg;
                RSC_ADDR_IRQ_MASK: rd_val[RSC_IRQ_W-1:0] = irq_mask_reg;
                default:           rd_val = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata_reg <= rd_val;
        end
    end

    // supply-low comes straight from the comparator, so synchronise it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sl_meta_reg <= 1'b0;
            sl_sync_reg <= 1'b0;
        end else begin
            sl_meta_reg <= supply_low_async;
            sl_sync_reg <= sl_meta_reg;
        end
    end

    // filter: the reset fires only once low persists for the full filter count
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            filt_reg <= '0;
        end else if (!sl_sync_reg || power_down || state_reg == RSC_HOLD) begin
            filt_reg <= '0;
        end else if (filt_reg != CNT_W'(BROWN_FILT_CYC)) begin
            filt_reg <= filt_reg + CNT_W'(1);
        end
    end

    assign brown_evt = sl_sync_reg && !power_down && state_reg != RSC_HOLD
                     && (filt_reg == CNT_W'(BROWN_FILT_CYC));
    assign wdt_run_evt = wdt_expire && run_mode_normal && state_reg != RSC_HOLD;

    assign key_bad  = (key_reg != RSC_KEY_NOP_A) && (key_reg != RSC_KEY_NOP_B);
    assign lvl_bad  = (level_reg != RSC_LVL_2V10) && (level_reg != RSC_LVL_2V55)
                    && (level_reg != RSC_LVL_3V15) && (level_reg != RSC_LVL_3V80);
    assign wkey_bad = (wdtctl_reg[7:RSC_WKEY_LSB] != RSC_WKEY_DIS)
                    && (wdtctl_reg[7:RSC_WKEY_LSB] != RSC_WKEY_EN);

    assign fire_hard = brown_evt || wdt_run_evt;
    assign fire_soft = (state_reg == RSC_DELAY)
                     && (cnt_reg == CNT_W'(SOFT_DELAY_CYC - 1));
    assign fire      = fire_hard || fire_soft;

    // one counter serves the soft delay and the reset hold
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg     <= RSC_HOLD;
            cnt_reg       <= '0;
            pend_key_reg  <= 1'b0;
            pend_lvl_reg  <= 1'b0;
            pend_wkey_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                RSC_IDLE: begin
                    cnt_reg <= '0;
                    if (fire_hard) begin
                        state_reg <= RSC_HOLD;
                    end else if (key_bad || lvl_bad || wkey_bad) begin
                        state_reg     <= RSC_DELAY;
                        pend_key_reg  <= key_bad;
                        pend_lvl_reg  <= lvl_bad;
                        pend_wkey_reg <= wkey_bad;
                    end
                end
                RSC_DELAY: begin
                    if (fire) begin
                        state_reg <= RSC_HOLD;
                        cnt_reg   <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + CNT_W'(1);
                    end
                end
                RSC_HOLD: begin
                    pend_key_reg  <= 1'b0;
                    pend_lvl_reg  <= 1'b0;
                    pend_wkey_reg <= 1'b0;
                    if (cnt_reg == CNT_W'(HOLD_CYC - 1)) begin
                        state_reg <= RSC_IDLE;
                        cnt_reg   <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + CNT_W'(1);
                    end
                end
            endcase
        end
    end

    assign core_reset = (state_reg == RSC_HOLD);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            por_reg <= 1'b1;
        end else if (state_reg == RSC_HOLD && cnt_reg == CNT_W'(HOLD_CYC - 1)) begin
            por_reg <= 1'b0;
        end
    end

    assign por_active = por_reg;

    // these are constants, held in flops so they read defined from reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            fetch_addr     <= '0;
            port_data_init <= '1;
            port_dir_init  <= '1;
        end else begin
            fetch_addr     <= '0;
            port_data_init <= '1;
            port_dir_init  <= '1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            key_reg <= RSC_KEY_RST;
        end else if (fire) begin
            key_reg <= RSC_KEY_RST;
        end else if (wr_key) begin
            key_reg <= hwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            level_reg <= RSC_LVL_RST;
        end else if (fire_soft && pend_lvl_reg) begin
            level_reg <= RSC_LVL_RST;
        end else if (fire) begin
            level_reg <= level_reg;
        end else if (wr_level) begin
            level_reg <= hwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wdtctl_reg <= RSC_WDTCTL_RST;
        end else if (fire) begin
            wdtctl_reg <= RSC_WDTCTL_RST;
        end else if (wr_wdtctl) begin
            wdtctl_reg <= hwdata[7:0];
        end
    end

    assign wdt_enable = (wdtctl_reg[7:RSC_WKEY_LSB] == RSC_WKEY_EN);

    // an invalid code decodes to the power-on threshold until it is restored
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            thr_reg <= RSC_THR_2V10;
        end else begin
            unique case (level_reg)
                RSC_LVL_2V55: thr_reg <= RSC_THR_2V55;
                RSC_LVL_3V15: thr_reg <= RSC_THR_3V15;
                RSC_LVL_3V80: thr_reg <= RSC_THR_3V80;
                default:      thr_reg <= RSC_THR_2V10;
            endcase
        end
    end

    assign brownout_threshold_sel = thr_reg;

    // write zero clears; a same-cycle set still wins
    always_comb begin
        cause_next = cause_reg;
        if (wr_cause) begin
            cause_next = cause_reg & hwdata[RSC_CAUSE_W-1:0];
        end
        if (fire_soft && pend_key_reg) begin
            cause_next[RSC_CAUSE_KEY] = 1'b1;
        end
        if (fire_hard) begin
            cause_next[RSC_CAUSE_BROWN] = 1'b1;
        end
        if (fire_soft && pend_lvl_reg) begin
            cause_next[RSC_CAUSE_LEVEL] = 1'b1;
        end
        if (fire_soft && pend_wkey_reg) begin
            cause_next[RSC_CAUSE_WKEY] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cause_reg <= '0;
        end else begin
            cause_reg <= cause_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            expire_reg <= 1'b0;
        end else if (wdt_expire) begin
            expire_reg <= 1'b1;
        end else if (wr_status && !hwdata[RSC_STATUS_EXP]) begin
            expire_reg <= 1'b0;
        end
    end

    // outside run mode an expiry only restarts program counter and stack
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pcsp_reg <= 1'b0;
        end else begin
            pcsp_reg <= wdt_expire && !run_mode_normal;
        end
    end

    assign pc_sp_reset = pcsp_reg;

    always_comb begin
        irq_evt                 = '0;
        irq_evt[RSC_IRQ_KEY]    = fire_soft && pend_key_reg;
        irq_evt[RSC_IRQ_BROWN]  = brown_evt;
        irq_evt[RSC_IRQ_LEVEL]  = fire_soft && pend_lvl_reg;
        irq_evt[RSC_IRQ_WKEY]   = fire_soft && pend_wkey_reg;
        irq_evt[RSC_IRQ_EXPIRE] = wdt_expire;
        irq_stat_next = irq_stat_reg;
        if (wr_istat) begin
            irq_stat_next = irq_stat_reg & ~hwdata[RSC_IRQ_W-1:0];
        end
        irq_stat_next = irq_stat_next | irq_evt;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_mask_reg <= '0;
        end else if (wr_imask) begin
            irq_mask_reg <= hwdata[RSC_IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule

//--- hdl/rsc_pkg.sv
package rsc_pkg;
    // register byte addresses
    localparam logic [7:0] RSC_ADDR_KEY      = 8'h00;
    localparam logic [7:0] RSC_ADDR_CAUSE    = 8'h04;
    localparam logic [7:0] RSC_ADDR_LEVEL    = 8'h08;
    localparam logic [7:0] RSC_ADDR_WDTCTL   = 8'h0C;
    localparam logic [7:0] RSC_ADDR_STATUS   = 8'h10;
    localparam logic [7:0] RSC_ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] RSC_ADDR_IRQ_MASK = 8'h18;
    localparam int         RSC_ADDR_W        = 8;

    // noise reset key
    localparam logic [7:0] RSC_KEY_NOP_A   = 8'h55;
    localparam logic [7:0] RSC_KEY_NOP_B   = 8'hAA;
    localparam logic [7:0] RSC_KEY_RST     = 8'h55;

    // brownout level codes
    localparam logic [7:0] RSC_LVL_2V10    = 8'h55;
    localparam logic [7:0] RSC_LVL_2V55    = 8'h33;
    localparam logic [7:0] RSC_LVL_3V15    = 8'h99;
    localparam logic [7:0] RSC_LVL_3V80    = 8'hAA;
    localparam logic [7:0] RSC_LVL_RST     = 8'h55;
    localparam logic [1:0] RSC_THR_2V10    = 2'h0;
    localparam logic [1:0] RSC_THR_2V55    = 2'h1;
    localparam logic [1:0] RSC_THR_3V15    = 2'h2;
    localparam logic [1:0] RSC_THR_3V80    = 2'h3;

    // watchdog control
    localparam logic [7:0] RSC_WDTCTL_RST  = 8'h53;
    localparam logic [4:0] RSC_WKEY_DIS    = 5'h15;
    localparam logic [4:0] RSC_WKEY_EN     = 5'h0A;
    localparam int         RSC_WKEY_LSB    = 3;

    // reset cause flag positions
    localparam int         RSC_CAUSE_W     = 4;
    localparam int         RSC_CAUSE_KEY   = 3;
    localparam int         RSC_CAUSE_BROWN = 2;
    localparam int         RSC_CAUSE_LEVEL = 1;
    localparam int         RSC_CAUSE_WKEY  = 0;
    localparam int         RSC_STATUS_EXP  = 0;

    // interrupt event positions
    localparam int         RSC_IRQ_W       = 5;
    localparam int         RSC_IRQ_KEY     = 0;
    localparam int         RSC_IRQ_BROWN   = 1;
    localparam int         RSC_IRQ_LEVEL   = 2;
    localparam int         RSC_IRQ_WKEY    = 3;
    localparam int         RSC_IRQ_EXPIRE  = 4;

    // timing
    localparam longint     RSC_CLK_HZ          = 40000000;
    localparam longint     RSC_NS_PER_S        = 1000000000;
    localparam longint     RSC_SOFT_DELAY_NS   = 16000;
    localparam longint     RSC_BROWN_FILT_NS   = 120000;
    localparam longint     RSC_HOLD_NS         = 1000;
    localparam int RSC_SOFT_DELAY_CYC =
        int'((RSC_SOFT_DELAY_NS * RSC_CLK_HZ + RSC_NS_PER_S - 1) / RSC_NS_PER_S);
    localparam int RSC_BROWN_FILT_CYC =
        int'((RSC_BROWN_FILT_NS * RSC_CLK_HZ + RSC_NS_PER_S - 1) / RSC_NS_PER_S);
    localparam int RSC_HOLD_CYC =
        int'((RSC_HOLD_NS * RSC_CLK_HZ + RSC_NS_PER_S - 1) / RSC_NS_PER_S);

    typedef enum logic [1:0] {RSC_IDLE, RSC_DELAY, RSC_HOLD} rsc_state_t;
endpackage

//--- dv/rsc_reset_source_controller_checker.sv
`timescale 1ns/1ps
module rsc_reset_source_controller_checker #(
    parameter int HOLD_CYC = 40,
    parameter int FETCH_W  = 16,
    parameter int PORT_W   = 8
) (
    // clock and reset
    input wire logic               clk_sys,
    input wire logic               sys_rst,
    // supply and watchdog
    input wire logic               supply_low_async,
    input wire logic               wdt_expire,
    input wire logic               run_mode_normal,
    input wire logic [1:0]         brownout_threshold_sel,
    input wire logic               wdt_enable,
    // reset outputs
    input wire logic               core_reset,
    input wire logic               por_active,
    input wire logic               pc_sp_reset,
    input wire logic [FETCH_W-1:0] fetch_addr,
    input wire logic [PORT_W-1:0]  port_data_init,
    input wire logic [PORT_W-1:0]  port_dir_init
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    logic [15:0] hold_cnt;

    // one cycle of slack over the hold count covers the release edge
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !core_reset) begin
            hold_cnt <= 16'h0000;
        end else begin
            hold_cnt <= hold_cnt + 16'h0001;
        end
    end

    sequence short_dip;
        !core_reset && $rose(supply_low_async) ##1 supply_low_async ##1 !supply_low_async;
    endsequence
    sequence run_expiry;
        wdt_expire && run_mode_normal && !core_reset;
    endsequence
    sequence sleep_expiry;
        wdt_expire && !run_mode_normal && !core_reset;
    endsequence

    AST_POR_HELD:
        assert property ($fell(sys_rst) |-> por_active && core_reset)
        else $error("reset release without power-on hold");
    AST_POR_INIT:
        assert property (por_active |-> fetch_addr == '0 && port_data_init == '1
                         && port_dir_init == '1)
        else $error("power-on fetch address or port presets wrong");
    AST_POR_END:
        assert property ($fell(por_active) |-> $fell(core_reset))
        else $error("power-on flag and core reset did not drop together");
    AST_HOLD_MIN:
        assert property ($rose(core_reset) |-> core_reset [*4])
        else $error("internal reset held too briefly");
    AST_HOLD_MAX:
        assert property (hold_cnt <= HOLD_CYC + 1)
        else $error("internal reset held too long");
    AST_SHORT_DIP:
        assert property (short_dip |-> !core_reset [*6])
        else $error("short supply dip caused a reset");
    AST_RUN_EXPIRY:
        assert property (run_expiry |-> ##[1:2] core_reset ##1 core_reset)
        else $error("run mode expiry gave no reset");
    AST_SLEEP_EXPIRY:
        assert property (sleep_expiry |=> pc_sp_reset && !core_reset ##1 !pc_sp_reset)
        else $error("sleep expiry did not pulse counter reset alone");
    AST_PCSP_CAUSE:
        assert property ($rose(pc_sp_reset) |-> $past(wdt_expire) && !$past(run_mode_normal))
        else $error("counter reset pulse without sleep expiry");
    AST_THR_POR:
        assert property ($fell(sys_rst) |-> brownout_threshold_sel == 2'h0 && wdt_enable)
        else $error("threshold or watchdog enable wrong after power-on");
endmodule

bind rsc_reset_source_controller rsc_reset_source_controller_checker #(
    .HOLD_CYC (HOLD_CYC),
    .FETCH_W  (FETCH_W),
    .PORT_W   (PORT_W)
) chk_u (.*);

//--- dv/tb_reset_source_controller.sv
`timescale 1ns/1ps
module tb_reset_source_controller;
    import rsc_pkg::*;
    localparam int SD = 8;
    localparam int HC = 4;
    logic        clk_sys, sys_rst, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, brownout_threshold_sel;
    logic        supply_low_async, power_down, wdt_expire, run_mode_normal;
    logic        wdt_enable, core_reset, por_active, pc_sp_reset, irq;
    logic [15:0] fetch_addr;
    logic [7:0]  port_data_init, port_dir_init;
    logic [7:0]  codes [4] = '{RSC_LVL_2V10, RSC_LVL_2V55, RSC_LVL_3V15, RSC_LVL_3V80};
    int          num_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          n;

    rsc_reset_source_controller #(.SOFT_DELAY_CYC(SD), .BROWN_FILT_CYC(8), .HOLD_CYC(HC)) dut_u (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .supply_low_async(supply_low_async),
        .power_down(power_down), .brownout_threshold_sel(brownout_threshold_sel),
        .wdt_expire(wdt_expire), .run_mode_normal(run_mode_normal), .wdt_enable(wdt_enable),
        .core_reset(core_reset), .por_active(por_active), .pc_sp_reset(pc_sp_reset),
        .fetch_addr(fetch_addr), .port_data_init(port_data_init),
        .port_dir_init(port_dir_init), .irq(irq));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // the whole sequence needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task give_verdict;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task idle(input int k);
        repeat (k) @(posedge clk_sys);
    endtask

    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask

    // waits for an internal reset, lifts any supply dip, waits for its end
    task fire(output int dly);
        dly = 0;
        while (core_reset !== 1'b1 && dly < 200) begin
            @(posedge clk_sys);
            dly++;
        end
        supply_low_async <= 1'b0;
        check("reset fired", core_reset, 1);
        repeat (200) if (core_reset === 1'b1) @(posedge clk_sys);
    endtask

    initial begin
        {sys_rst, hsel, hwrite, htrans, haddr, hwdata} = '0;
        sys_rst = 1'b1;
        {supply_low_async, power_down, wdt_expire} = '0;
        run_mode_normal = 1'b1;
        idle(6);
        sys_rst <= 1'b0;
        idle(1);
        check("fetch_addr", fetch_addr, 32'h0);
        check("port init", {port_dir_init, port_data_init}, 32'hFFFF);
        check("por_active", por_active, 32'h1);
        rchk("key por", RSC_ADDR_KEY, 32'h55);
        rchk("level por", RSC_ADDR_LEVEL, 32'h55);
        rchk("cause por", RSC_ADDR_CAUSE, 32'h0);
        rchk("unmapped", 8'h40, 32'h0);
        check("hresp", hresp, 32'h0);
        bus(1'b1, RSC_ADDR_KEY, 32'hAA);
        idle(3 * SD);
        check("nop key", core_reset, 32'h0);
        bus(1'b1, RSC_ADDR_IRQ_MASK, 32'h1);
        bus(1'b1, RSC_ADDR_KEY, 32'h0);
        fire(n);
        check("soft delay", 32'(n >= SD && n <= SD + 4), 32'h1);
        rchk("key flag", RSC_ADDR_CAUSE, 32'h8);
        rchk("key restored", RSC_ADDR_KEY, 32'h55);
        check("irq raised", irq, 32'h1);
        bus(1'b1, RSC_ADDR_CAUSE, 32'hFFFFFFFF);
        rchk("sticky", RSC_ADDR_CAUSE, 32'h8);
        bus(1'b1, RSC_ADDR_CAUSE, 32'hF7);
        rchk("cleared", RSC_ADDR_CAUSE, 32'h0);
        bus(1'b1, RSC_ADDR_IRQ_STAT, 32'h1F);
        idle(1);
        check("irq cleared", irq, 32'h0);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, RSC_ADDR_LEVEL, {24'h0, codes[i]});
            idle(2);
            check("threshold", brownout_threshold_sel, i);
        end
        check("valid level", core_reset, 32'h0);
        supply_low_async <= 1'b1;
        idle(2);
        supply_low_async <= 1'b0;
        idle(20);
        check("dip ignored", core_reset, 32'h0);
        supply_low_async <= 1'b1;
        idle(8);
        supply_low_async <= 1'b0;
        idle(20);
        check("filter length dip", core_reset, 32'h0);
        power_down <= 1'b1;
        supply_low_async <= 1'b1;
        idle(30);
        check("power down", core_reset, 32'h0);
        power_down <= 1'b0;
        fire(n);
        check("filter time", 32'(n >= 9 && n <= 12), 32'h1);
        rchk("brown flag", RSC_ADDR_CAUSE, 32'h4);
        rchk("level kept", RSC_ADDR_LEVEL, 32'hAA);
        check("threshold kept", brownout_threshold_sel, 32'h3);
        bus(1'b1, RSC_ADDR_CAUSE, 32'h0);
        bus(1'b1, RSC_ADDR_LEVEL, 32'h12);
        fire(n);
        check("level delay", 32'(n >= SD && n <= SD + 4), 32'h1);
        rchk("level flag", RSC_ADDR_CAUSE, 32'h2);
        rchk("level restored", RSC_ADDR_LEVEL, 32'h55);
        check("irq masked", irq, 32'h0);
        bus(1'b1, RSC_ADDR_IRQ_MASK, 32'h4);
        idle(1);
        check("irq unmasked", irq, 32'h1);
        bus(1'b1, RSC_ADDR_IRQ_STAT, 32'h1F);
        bus(1'b1, RSC_ADDR_CAUSE, 32'h0);
        bus(1'b1, RSC_ADDR_WDTCTL, 32'hAB);
        idle(3 * SD);
        check("wdt disabled", {wdt_enable, core_reset}, 32'h0);
        bus(1'b1, RSC_ADDR_WDTCTL, 32'h0);
        fire(n);
        rchk("wkey flag", RSC_ADDR_CAUSE, 32'h1);
        rchk("wkey restored", RSC_ADDR_WDTCTL, 32'h53);
        check("wdt enabled", wdt_enable, 32'h1);
        bus(1'b1, RSC_ADDR_CAUSE, 32'h0);
        run_mode_normal <= 1'b0;
        wdt_expire <= 1'b1;
        idle(1);
        wdt_expire <= 1'b0;
        idle(1);
        check("pc_sp pulse", pc_sp_reset, 32'h1);
        idle(2);
        check("sleep expiry", core_reset, 32'h0);
        rchk("expiry flag", RSC_ADDR_STATUS, 32'h1);
        bus(1'b1, RSC_ADDR_STATUS, 32'h0);
        rchk("expiry cleared", RSC_ADDR_STATUS, 32'h0);
        run_mode_normal <= 1'b1;
        wdt_expire <= 1'b1;
        idle(1);
        wdt_expire <= 1'b0;
        fire(n);
        rchk("run expiry flag", RSC_ADDR_STATUS, 32'h1);
        rchk("run expiry cause", RSC_ADDR_CAUSE, 32'h4);
        sys_rst <= 1'b1;
        idle(2);
        sys_rst <= 1'b0;
        idle(1);
        rchk("cause after por", RSC_ADDR_CAUSE, 32'h0);
        give_verdict();
    end
endmodule
